// >>> hw/fcd_array_dec.sv
// command sequencer for one flash array
`timescale 1ns/100ps
module fcd_array_dec
	import fcd_pkg::*;
#(
	parameter bit          HAS_ID    = 1'b1,
	parameter int unsigned QUEUE_CYC = FCD_QUEUE_CYC,
	parameter int unsigned GAP_CYC   = FCD_GAP_CYC
)
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// decoded write events
	fcd_wr_if.dst            wr,
	// engine status and host read
	input  wire logic        engine_done_i,
	input  wire logic        engine_fail_i,
	input  wire logic        read_i,
	// results
	output logic             op_start_o,
	output fcd_op_type       op_kind_o,
	output logic [15:0]      op_addr_o,
	output logic [15:0]      op_data_o,
	output logic             busy_o,
	output logic             suspended_o,
	output logic             error_o,
	output logic             read_mode_o,
	output logic [7:0]       special_data_o,
	output logic             special_valid_o
);
	fcd_state_type          state_q, state_d;
	fcd_op_type             kind_q, kind_d;
	logic                   start_q, start_d;
	logic [15:0]            pa_q, pa_d, pd_q, pd_d;
	logic                   busy_q, busy_d, susp_q, susp_d, err_q, err_d;
	logic                   erasing_q, erasing_d;
	logic [FCD_CNT_W-1:0]   gap_q, gap_d;
	logic                   byp_q, byp_d;
	logic [7:0]             byte_v;
	logic                   adr_aaa, adr_554;
	logic                   data_phase;

	assign byte_v  = wr.data[7:0];
	// a program word is data, never a command byte
	assign data_phase = state_q == FCD_PROG_DATA
		|| state_q == FCD_BYP_PROG;
	assign adr_aaa = wr.addr_low == FCD_UNLOCK1_ADDR; // RULE_14
	assign adr_554 = wr.addr_low == FCD_UNLOCK2_ADDR; // RULE_14

	// next-state decode: one step per written byte
	always_comb
	begin
		state_d   = state_q;
		kind_d    = kind_q;
		start_d   = 1'b0;
		pa_d      = pa_q;
		pd_d      = pd_q;
		busy_d    = busy_q;
		susp_d    = susp_q;
		err_d     = err_q;
		erasing_d = erasing_q;
		byp_d     = byp_q;
		gap_d     = gap_q;
		// the engine finishing ends busy and erase
		if (engine_done_i)
		begin
			busy_d    = 1'b0; // RULE_22
			erasing_d = 1'b0;
			susp_d    = 1'b0;
		end
		// gap timer counts only inside an unfinished sequence
		if (state_q != FCD_READ && state_q != FCD_AUTOSEL
			&& state_q != FCD_BYPASS)
		begin
			if (gap_q == FCD_CNT_W'(0))
			begin
				// queue window closes: start the gathered erase
				if (state_q == FCD_ERASE_QUEUE)
				begin
					start_d   = 1'b1; // RULE_08
					busy_d    = 1'b1;
					erasing_d = 1'b1;
				end
				state_d = byp_q ? FCD_BYPASS : FCD_READ; // RULE_16
			end
			else
				gap_d = gap_q - FCD_CNT_W'(1);
		end
		if (wr.wr_fall && wr.sel)
			pa_d = wr.addr; // RULE_07
		if (wr.wr_rise && wr.sel)
		begin
			gap_d   = FCD_CNT_W'(GAP_CYC);
			state_d = FCD_READ; // RULE_16 default on a bad byte
			if (byte_v == FCD_CMD_RESET && !byp_q && !data_phase)
			begin
				err_d = 1'b0; // RULE_23
				state_d = FCD_READ; // RULE_05
			end
			else if (busy_q && !susp_q && erasing_q && !data_phase
				&& kind_q == FCD_OP_SECTOR
				&& byte_v == FCD_CMD_SUSPEND)
			begin
				susp_d  = 1'b1; // RULE_10
				state_d = FCD_READ;
			end
			else if (susp_q && byte_v == FCD_CMD_SECTOR
				&& state_q == FCD_READ)
			begin
				susp_d  = 1'b0; // RULE_11
				state_d = FCD_READ;
			end
			else
			begin
				case (state_q)
				FCD_READ:
					if (byte_v == FCD_CMD_UNLOCK1 && adr_aaa)
						state_d = FCD_UNL1; // RULE_02
				FCD_UNL1:
					if (byte_v == FCD_CMD_UNLOCK2 && adr_554)
						state_d = FCD_UNL2; // RULE_02
				FCD_UNL2:
					if (adr_aaa && byte_v == FCD_CMD_AUTOSEL)
						state_d = FCD_AUTOSEL;
					else if (adr_aaa && byte_v == FCD_CMD_PROGRAM
						&& !(busy_q && !susp_q))
						state_d = FCD_PROG_DATA; // RULE_06
					else if (adr_aaa && byte_v == FCD_CMD_ERASE
						&& !busy_q)
						state_d = FCD_ERASE_80;
					else if (adr_aaa && byte_v == FCD_CMD_BYPASS)
					begin
						byp_d   = 1'b1; // RULE_12
						state_d = FCD_BYPASS;
					end
				FCD_AUTOSEL:
					state_d = FCD_READ; // leave by reset or any write
				FCD_PROG_DATA, FCD_BYP_PROG:
				begin
					pd_d    = wr.data; // RULE_07
					kind_d  = FCD_OP_PROG;
					start_d = 1'b1; // RULE_17
					busy_d  = 1'b1;
					state_d = byp_q ? FCD_BYPASS : FCD_READ;
				end
				FCD_ERASE_80:
					if (byte_v == FCD_CMD_UNLOCK1 && adr_aaa)
						state_d = FCD_ERASE_UNL1;
				FCD_ERASE_UNL1:
					if (byte_v == FCD_CMD_UNLOCK2 && adr_554)
						state_d = FCD_ERASE_UNL2;
				FCD_ERASE_UNL2:
					if (byte_v == FCD_CMD_BULK && adr_aaa)
					begin
						kind_d    = FCD_OP_BULK; // RULE_09
						start_d   = 1'b1;
						busy_d    = 1'b1;
						erasing_d = 1'b1;
					end
					else if (byte_v == FCD_CMD_SECTOR)
					begin
						kind_d  = FCD_OP_SECTOR; // RULE_08
						gap_d   = FCD_CNT_W'(QUEUE_CYC);
						state_d = FCD_ERASE_QUEUE;
					end
				FCD_ERASE_QUEUE:
					if (byte_v == FCD_CMD_SECTOR)
					begin
						gap_d   = FCD_CNT_W'(QUEUE_CYC); // RULE_08
						state_d = FCD_ERASE_QUEUE;
					end
				FCD_BYPASS:
					if (byte_v == FCD_CMD_PROGRAM)
						state_d = FCD_BYP_PROG; // RULE_12
					else if (byte_v == FCD_CMD_AUTOSEL)
						state_d = FCD_BYP_EXIT;
					else
						state_d = FCD_BYPASS;
				FCD_BYP_EXIT:
					if (byte_v == FCD_CMD_BYP_EXIT)
					begin
						byp_d   = 1'b0; // RULE_13
						state_d = FCD_READ;
					end
					else
						state_d = FCD_BYPASS;
				default:
					state_d = FCD_READ;
				endcase
			end
		end
		// a failure in the same cycle as a reset command wins
		if (engine_fail_i)
			err_d = 1'b1;
	end

	// registers; reset lands in read mode
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q   <= FCD_READ; // RULE_20
			kind_q    <= FCD_OP_NONE;
			start_q   <= 1'b0;
			pa_q      <= 16'h0000;
			pd_q      <= 16'h0000;
			busy_q    <= 1'b0;
			susp_q    <= 1'b0;
			err_q     <= 1'b0;
			erasing_q <= 1'b0;
			byp_q     <= 1'b0;
			gap_q     <= FCD_CNT_W'(0);
		end
		else
		begin
			state_q   <= state_d;
			kind_q    <= kind_d;
			start_q   <= start_d;
			pa_q      <= pa_d;
			pd_q      <= pd_d;
			busy_q    <= busy_d;
			susp_q    <= susp_d;
			err_q     <= err_d;
			erasing_q <= erasing_d;
			byp_q     <= byp_d;
			gap_q     <= gap_d;
		end
	end

	// special-read answer in autoselect mode
	always_comb
	begin
		special_valid_o = 1'b0;
		special_data_o  = 8'h00;
		if (state_q == FCD_AUTOSEL && read_i)
		begin
			if (wr.addr_low == FCD_ID_ADDR && HAS_ID)
			begin
				special_valid_o = 1'b1; // RULE_03 RULE_19
				special_data_o  = FCD_ID_VALUE;
			end
			else if (wr.addr_low == FCD_PROT_ADDR)
			begin
				special_valid_o = 1'b1; // RULE_04
				special_data_o  = FCD_PROT_NO;
			end
		end
	end

	assign op_start_o  = start_q; // RULE_24 only full sequences start
	assign op_kind_o   = kind_q;
	assign op_addr_o   = pa_q;
	assign op_data_o   = pd_q;
	assign busy_o      = busy_q;
	assign suspended_o = susp_q;
	assign error_o     = err_q;
	assign read_mode_o = state_q == FCD_READ && !byp_q; // RULE_01
endmodule

// >>> hw/fcd_pkg.sv
// package of constants and types for the flash command decoder
// Overview of operation
// [RULE_01] read mode passes array data without commands
// [RULE_02] commands open with AA at AAA, 55 at 554
// [RULE_03] 90 command then read 002 gives identifier
// [RULE_04] 90 command then read 004 gives protection
// [RULE_05] F0 anywhere returns to read mode; the code ignores F0 in bypass and as a program data word
// [RULE_06] program: unlock, A0, then data word
// [RULE_07] address on strobe fall, data on rise
// [RULE_08] sector erase 80, unlock, 30; more within 80us
// [RULE_09] bulk erase: unlock, 80, unlock, 10
// [RULE_10] B0 suspends running sector erase only
// [RULE_11] 30 resumes only a suspended erase
// [RULE_12] 20 enters bypass; A0 then data programs
// [RULE_13] bypass left by 90 then 00
// [RULE_14] decode address bits 11..0 with select active
// [RULE_15] host writes commands as even byte writes
// [RULE_16] bad byte or time-out returns read mode; in bypass the code returns to bypass instead
// [RULE_17] bytes decoded; execute when sequence complete
// [RULE_18] any select of array routes command there
// [RULE_19] secondary array lacks identifier read
// [RULE_20] power-up enters read mode
// [RULE_21] host runs code from the other array
// [RULE_22] ready/busy low while program or erase runs
// [RULE_23] reset command clears error flag
// [RULE_24] stray writes leave array contents unchanged
package fcd_pkg;
	localparam logic [11:0] FCD_UNLOCK1_ADDR = 12'hAAA;
	localparam logic [11:0] FCD_UNLOCK2_ADDR = 12'h554;
	localparam logic [11:0] FCD_ID_ADDR      = 12'h002;
	localparam logic [11:0] FCD_PROT_ADDR    = 12'h004;
	localparam logic [7:0]  FCD_CMD_UNLOCK1  = 8'hAA;
	localparam logic [7:0]  FCD_CMD_UNLOCK2  = 8'h55;
	localparam logic [7:0]  FCD_CMD_AUTOSEL  = 8'h90;
	localparam logic [7:0]  FCD_CMD_PROGRAM  = 8'hA0;
	localparam logic [7:0]  FCD_CMD_ERASE    = 8'h80;
	localparam logic [7:0]  FCD_CMD_SECTOR   = 8'h30;
	localparam logic [7:0]  FCD_CMD_BULK     = 8'h10;
	localparam logic [7:0]  FCD_CMD_SUSPEND  = 8'hB0;
	localparam logic [7:0]  FCD_CMD_RESET    = 8'hF0;
	localparam logic [7:0]  FCD_CMD_BYPASS   = 8'h20;
	localparam logic [7:0]  FCD_CMD_BYP_EXIT = 8'h00;
	localparam logic [7:0]  FCD_PROT_YES     = 8'h01;
	localparam logic [7:0]  FCD_PROT_NO      = 8'h00;
	// identifier value is arbitrary
	localparam logic [7:0]  FCD_ID_VALUE     = 8'h5A;
	localparam int          FCD_CLK_MHZ      = 250;
	// queue window for further sector addresses, microseconds
	localparam int          FCD_QUEUE_US     = 80;
	localparam int          FCD_QUEUE_CYC    = FCD_QUEUE_US * FCD_CLK_MHZ;
	// gap allowed between command bytes, microseconds
	localparam int          FCD_GAP_US       = 80;
	localparam int          FCD_GAP_CYC      = FCD_GAP_US * FCD_CLK_MHZ;
	localparam int          FCD_CNT_W        = 16;

	typedef enum logic [3:0] {
		FCD_READ, FCD_UNL1, FCD_UNL2, FCD_AUTOSEL, FCD_PROG_DATA,
		FCD_ERASE_80, FCD_ERASE_UNL1, FCD_ERASE_UNL2, FCD_ERASE_QUEUE,
		FCD_BYPASS, FCD_BYP_PROG, FCD_BYP_EXIT
	} fcd_state_type;

	typedef enum logic [1:0] {
		FCD_OP_NONE, FCD_OP_PROG, FCD_OP_SECTOR, FCD_OP_BULK
	} fcd_op_type;
endpackage

// >>> hw/fcd_wr_if.sv
// interface carrying one decoded write strobe to the per-array decoder
`timescale 1ns/100ps
interface fcd_wr_if;
	logic        wr_fall;
	logic        wr_rise;
	logic        sel;
	logic [11:0] addr_low;
	logic [15:0] addr;
	logic [15:0] data;
	modport src (output wr_fall, wr_rise, sel, addr_low, addr, data);
	modport dst (input wr_fall, wr_rise, sel, addr_low, addr, data);
endinterface

// >>> hw/fcd_top.sv
// top of the flash command decoder for both arrays
`timescale 1ns/100ps
module fcd_top
	import fcd_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// host bus
	input  wire logic        low_byte_write_strobe_n_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] data_i,
	input  wire logic [7:0]  primary_sector_selects_i,
	input  wire logic [3:0]  secondary_sector_selects_i,
	// protection status per sector
	input  wire logic [7:0]  primary_protect_i,
	input  wire logic [3:0]  secondary_protect_i,
	// program/erase engines
	input  wire logic [1:0]  engine_done_i,
	input  wire logic [1:0]  engine_fail_i,
	output logic [1:0]       op_start_o,
	output logic [3:0]       op_kind_o,
	output logic [15:0]      op_addr_o,
	output logic [15:0]      op_data_o,
	// status
	output logic             ready_busy_output_o,
	output logic [1:0]       error_flag_bit_o,
	output logic [1:0]       read_mode_o,
	output logic [1:0]       suspended_o,
	output logic [7:0]       special_data_o,
	output logic             special_valid_o
);
	logic        strobe_q, strobe_d;
	logic        fall, rise;
	logic [1:0]  sel;
	logic [1:0]  start, busy, err, rmode, susp, sval;
	fcd_op_type  kind [2];
	logic [15:0] oaddr [2], odata [2];
	logic [7:0]  sdat [2];
	logic        prot_bit;
	logic [15:0] addr_d, data_d;
	logic [3:0]  kind_d;
	logic [7:0]  sdat_d;

	assign strobe_d = low_byte_write_strobe_n_i;
	assign fall = strobe_q && !low_byte_write_strobe_n_i;
	assign rise = !strobe_q && low_byte_write_strobe_n_i;
	assign sel[0] = |primary_sector_selects_i; // RULE_18
	assign sel[1] = |secondary_sector_selects_i; // RULE_18
	assign prot_bit = |(primary_protect_i & primary_sector_selects_i)
		|| |(secondary_protect_i & secondary_sector_selects_i);

	// one sequencer per array; only the primary answers the identifier
	for (genvar g = 0; g < 2; g++)
	begin : g_arr
		fcd_wr_if wr_if ();
		assign wr_if.wr_fall  = fall;
		assign wr_if.wr_rise  = rise;
		assign wr_if.sel      = sel[g];
		assign wr_if.addr_low = addr_i[11:0]; // RULE_14
		assign wr_if.addr     = addr_i;
		assign wr_if.data     = data_i;
		fcd_array_dec #(.HAS_ID(g == 0)) u_dec (
			.ref_clk_i       (ref_clk_i),
			.rst_n_i         (rst_n_i),
			.wr              (wr_if),
			.engine_done_i   (engine_done_i[g]),
			.engine_fail_i   (engine_fail_i[g]),
			.read_i          (rd_i && sel[g]),
			.op_start_o      (start[g]),
			.op_kind_o       (kind[g]),
			.op_addr_o       (oaddr[g]),
			.op_data_o       (odata[g]),
			.busy_o          (busy[g]),
			.suspended_o     (susp[g]),
			.error_o         (err[g]),
			.read_mode_o     (rmode[g]),
			.special_data_o  (sdat[g]),
			.special_valid_o (sval[g])
		);
	end

	// steer address and data from the array that started; kind carries both arrays
	always_comb
	begin
		addr_d = start[1] ? oaddr[1] : oaddr[0];
		data_d = start[1] ? odata[1] : odata[0];
		kind_d = {kind[1], kind[0]};
		sdat_d = sval[1] ? sdat[1] : sdat[0];
		// protection answer reflects the selected sector
		if (|sval && sdat_d == FCD_PROT_NO && prot_bit
			&& addr_i[11:0] == FCD_PROT_ADDR)
			sdat_d = FCD_PROT_YES; // RULE_04
	end

	// all outputs registered
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			strobe_q            <= 1'b1;
			op_start_o          <= 2'h0;
			op_kind_o           <= 4'h0;
			op_addr_o           <= 16'h0000;
			op_data_o           <= 16'h0000;
			ready_busy_output_o <= 1'b1;
			error_flag_bit_o    <= 2'h0;
			read_mode_o         <= 2'h3;
			suspended_o         <= 2'h0;
			special_data_o      <= 8'h00;
			special_valid_o     <= 1'b0;
		end
		else
		begin
			strobe_q            <= strobe_d;
			op_start_o          <= start;
			op_kind_o           <= kind_d;
			op_addr_o           <= addr_d;
			op_data_o           <= data_d;
			ready_busy_output_o <= ~|busy; // RULE_22
			error_flag_bit_o    <= err;
			read_mode_o         <= rmode;
			suspended_o         <= susp;
			special_data_o      <= sdat_d;
			special_valid_o     <= |sval;
		end
	end
endmodule

// >>> test/fcd_top_asserts.sv
// concurrent checks on the flash command decoder top ports
`timescale 1ns/100ps
module fcd_top_asserts
	import fcd_pkg::*;
(
	// clock, reset, host bus, protection and engine failure
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        low_byte_write_strobe_n_i,
	input wire logic        rd_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0]  primary_sector_selects_i,
	input wire logic [3:0]  secondary_sector_selects_i,
	input wire logic [7:0]  primary_protect_i,
	input wire logic [1:0]  engine_fail_i,
	// decoder outputs
	input wire logic [1:0]  op_start_o,
	input wire logic [3:0]  op_kind_o,
	input wire logic        ready_busy_output_o,
	input wire logic [1:0]  error_flag_bit_o,
	input wire logic [1:0]  read_mode_o,
	input wire logic [1:0]  suspended_o,
	input wire logic [7:0]  special_data_o,
	input wire logic        special_valid_o
);
	logic       strobe_q;
	logic       strobe_d;
	logic [2:0] since_q;
	logic [2:0] since_d;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// cycles since the strobe last rose, saturating so it never wraps
	always_comb
	begin
		strobe_d = low_byte_write_strobe_n_i;
		since_d = (since_q == 3'h7) ? 3'h7 : since_q + 3'h1;
		if (!strobe_q && low_byte_write_strobe_n_i)
			since_d = 3'h0;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			strobe_q <= 1'b1;
			since_q  <= 3'h7;
		end
		else
		begin
			strobe_q <= strobe_d;
			since_q  <= since_d;
		end
	end

	// start pulse shape and the busy level that follows it
	sequence start_once;
		op_start_o[0] ##1 !op_start_o[0];
	endsequence
	sequence busy_soon;
		##[0:2] !ready_busy_output_o;
	endsequence

	reset_state_a: assert property (
		$rose(rst_n_i) |-> read_mode_o == 2'h3 && ready_busy_output_o)
		else $error("decoder not idle after reset");
	start_once_a: assert property (op_start_o[0] |-> start_once)
		else $error("start pulse too long");
	start_kind_a: assert property (
		op_start_o[0] |-> op_kind_o[1:0] != 2'h0)
		else $error("start without operation kind");
	busy_follow_a: assert property (op_start_o != 2'h0 |-> busy_soon)
		else $error("ready not low after start");
	err_rise_a: assert property (
		$rose(error_flag_bit_o[0]) |->
		$past(engine_fail_i[0]) || $past(engine_fail_i[0], 2))
		else $error("error flag set without failure");
	err_clear_a: assert property (
		$fell(error_flag_bit_o[0]) |-> since_q <= 3'h4)
		else $error("error flag cleared without a write");
	suspend_busy_a: assert property (
		$rose(suspended_o[0]) |-> !$past(ready_busy_output_o))
		else $error("suspend while nothing ran");
	prot_answer_a: assert property (
		special_valid_o && $past(rd_i) &&
		$past(addr_i[11:0]) == FCD_PROT_ADDR &&
		$past(secondary_sector_selects_i) == 4'h0 &&
		$past(primary_sector_selects_i) != 8'h00 |->
		special_data_o == {7'h00, |($past(primary_sector_selects_i)
		& $past(primary_protect_i))})
		else $error("wrong protection answer");
endmodule

bind fcd_top fcd_top_asserts i_fcd_top_asserts
(
	.ref_clk_i, .rst_n_i, .low_byte_write_strobe_n_i, .rd_i, .addr_i,
	.primary_sector_selects_i, .secondary_sector_selects_i,
	.primary_protect_i, .engine_fail_i, .op_start_o, .op_kind_o,
	.ready_busy_output_o, .error_flag_bit_o, .read_mode_o, .suspended_o,
	.special_data_o, .special_valid_o
);

// >>> test/fcd_host_model.sv
// host model driving write and read cycles on the flash bus
`timescale 1ns/100ps
module fcd_host_model
(
	// clock and read answer
	input  wire logic        ref_clk_i,
	input  wire logic [7:0]  special_data_i,
	// bus towards the decoder
	output logic             strobe_n_o,
	output logic             rd_o,
	output logic [15:0]      addr_o,
	output logic [15:0]      data_o,
	output logic [7:0]       psel_o,
	output logic [3:0]       ssel_o
);
	// power-up: selects low, strobe high
	initial
	begin
		strobe_n_o = 1'b1;
		rd_o = 1'b0;
		addr_o = 16'h0000;
		data_o = 16'hFFFF;
		psel_o = 8'h00;
		ssel_o = 4'h0;
	end

	// one write; released address and data show the inverse, never stale values
	task automatic wr(input logic [7:0] ps, input logic [3:0] ss,
		input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr_o <= {a[15:1], 1'b0};
		data_o <= d;
		psel_o <= ps;
		ssel_o <= ss;
		strobe_n_o <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		strobe_n_o <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		psel_o <= 8'h00;
		ssel_o <= 4'h0;
		addr_o <= ~a;
		data_o <= ~d;
	endtask

	// one read held long enough for the registered answer
	task automatic look(input logic [7:0] ps, input logic [3:0] ss,
		input logic [15:0] a, output logic [7:0] q);
		@(posedge ref_clk_i);
		addr_o <= a;
		psel_o <= ps;
		ssel_o <= ss;
		// only special reads of the commanded array; code runs elsewhere
		rd_o <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		q = special_data_i;
		rd_o <= 1'b0;
		psel_o <= 8'h00;
		ssel_o <= 4'h0;
		addr_o <= ~a;
	endtask
endmodule

// >>> test/flash_command_decoder_test.sv
// self-checking bench for the flash command decoder
`timescale 1ns/100ps
module flash_command_decoder_test
	import fcd_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n, strobe_n, rd, ready, svalid;
	logic [15:0] addr, data, op_addr, op_data, addr_s, data_s;
	logic [7:0]  psel, pprot, sdata, q;
	logic [3:0]  ssel, sprot, op_kind, kind_s;
	logic [1:0]  done, fail, op_start, err, rmode, susp, seen;
	int          bad_count = 0;
	int          checks = 0;
	int          cycles = 0;

	// 250 MHz clock
	always #2 clk = ~clk;

	fcd_top i_fcd_top (.ref_clk_i(clk), .rst_n_i(rst_n),
		.low_byte_write_strobe_n_i(strobe_n), .rd_i(rd), .addr_i(addr),
		.data_i(data), .primary_sector_selects_i(psel),
		.secondary_sector_selects_i(ssel), .primary_protect_i(pprot),
		.secondary_protect_i(sprot), .engine_done_i(done),
		.engine_fail_i(fail), .op_start_o(op_start), .op_kind_o(op_kind),
		.op_addr_o(op_addr), .op_data_o(op_data),
		.ready_busy_output_o(ready), .error_flag_bit_o(err),
		.read_mode_o(rmode), .suspended_o(susp),
		.special_data_o(sdata), .special_valid_o(svalid));
	fcd_host_model i_fcd_host_model (.ref_clk_i(clk),
		.special_data_i(sdata), .strobe_n_o(strobe_n), .rd_o(rd),
		.addr_o(addr), .data_o(data), .psel_o(psel), .ssel_o(ssel));

	// catch one-cycle start pulses in their own cycle
	always @(posedge clk)
	begin
		if (op_start != 2'b00)
		begin
			seen <= seen | op_start;
			kind_s <= op_kind;
			addr_s <= op_addr;
			data_s <= op_data;
		end
	end

	// hang guard, well above the erase queue and the time-out waits
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string what, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", what, e, g);
			bad_count++;
		end
	endtask

	task w(input logic [7:0] ps, input logic [3:0] ss,
		input logic [15:0] a, input logic [15:0] d);
		i_fcd_host_model.wr(ps, ss, a, d);
	endtask

	task unlock(input logic [7:0] ps, input logic [3:0] ss);
		w(ps, ss, 16'h5AAA, 16'h00AA);
		w(ps, ss, 16'hE554, 16'h0055);
	endtask

	task wait_start(input int n);
		for (int i = 0; i < n && seen == 2'b00; i++)
			@(posedge clk);
		@(posedge clk);
	endtask

	task eng(input logic [1:0] m, input bit f);
		@(posedge clk);
		done <= f ? 2'b00 : m;
		fail <= f ? m : 2'b00;
		@(posedge clk);
		done <= 2'b00;
		fail <= 2'b00;
		repeat (3) @(posedge clk);
	endtask

	task t_program;
		seen = 2'b00;
		unlock(8'h04, 4'h0);
		w(8'h04, 4'h0, 16'hCAAA, 16'h00A0);
		w(8'h04, 4'h0, 16'h3456, 16'hBEEF);
		wait_start(20);
		chk("start", 16'h0001, 16'(seen));
		chk("kind", 16'h0001, 16'(kind_s));
		chk("address", 16'h3456, addr_s);
		chk("word", 16'hBEEF, data_s);
		chk("busy", 16'h0000, 16'(ready));
		eng(2'b01, 1'b0);
		chk("ready", 16'h0001, 16'(ready));
		$display("program test ended");
	endtask

	task t_autosel;
		unlock(8'h01, 4'h0);
		w(8'h01, 4'h0, 16'h2AAA, 16'h0090);
		i_fcd_host_model.look(8'h01, 4'h0, 16'h7002, q);
		chk("ident", 16'(FCD_ID_VALUE), 16'(q));
		chk("ident valid", 16'h0001, 16'(svalid));
		pprot <= 8'h02;
		i_fcd_host_model.look(8'h02, 4'h0, 16'h1004, q);
		chk("protected", 16'h0001, 16'(q));
		i_fcd_host_model.look(8'h01, 4'h0, 16'h1004, q);
		chk("unprotected", 16'h0000, 16'(q));
		w(8'h01, 4'h0, 16'h0000, 16'h00F0);
		chk("read mode", 16'h0003, 16'(rmode));
		sprot <= 4'h2;
		unlock(8'h00, 4'h2);
		w(8'h00, 4'h2, 16'h0AAA, 16'h0090);
		i_fcd_host_model.look(8'h00, 4'h2, 16'h0004, q);
		chk("second protected", 16'h0001, 16'(q));
		i_fcd_host_model.look(8'h00, 4'h2, 16'h0002, q);
		chk("second no ident", 16'h0000, 16'(q));
		chk("second no valid", 16'h0000, 16'(svalid));
		w(8'h00, 4'h2, 16'h0000, 16'h00F0);
		chk("second read mode", 16'h0003, 16'(rmode));
		$display("special read test ended");
	endtask

	task t_bad;
		seen = 2'b00;
		unlock(8'h01, 4'h0);
		w(8'h01, 4'h0, 16'h0AAA, 16'h0077);
		chk("after bad byte", 16'h0003, 16'(rmode));
		w(8'h01, 4'h0, 16'h0AAA, 16'h00AA);
		w(8'h01, 4'h0, 16'h0556, 16'h0055);
		w(8'h01, 4'h0, 16'h0AAA, 16'h00A0);
		w(8'h01, 4'h0, 16'h0100, 16'h1111);
		unlock(8'h01, 4'h0);
		chk("sequence open", 16'h0002, 16'(rmode));
		repeat (FCD_GAP_CYC + 10) @(posedge clk);
		chk("after time-out", 16'h0003, 16'(rmode));
		w(8'h01, 4'h0, 16'h0AAA, 16'h00A0);
		w(8'h01, 4'h0, 16'h0100, 16'h2222);
		repeat (4) @(posedge clk);
		chk("stray start", 16'h0000, 16'(seen));
		$display("broken sequence test ended");
	endtask

	task t_bypass;
		seen = 2'b00;
		unlock(8'h00, 4'h1);
		w(8'h00, 4'h1, 16'h0AAA, 16'h0020);
		chk("bypass mode", 16'h0001, 16'(rmode));
		w(8'h00, 4'h1, 16'h0010, 16'h00A0);
		w(8'h00, 4'h1, 16'h0200, 16'h1234);
		wait_start(20);
		chk("bypass start", 16'h0002, 16'(seen));
		chk("bypass kind", 16'h0001, 16'(kind_s[3:2]));
		chk("bypass word", 16'h1234, data_s);
		eng(2'b10, 1'b0);
		w(8'h00, 4'h1, 16'h0000, 16'h0090);
		w(8'h00, 4'h1, 16'h0000, 16'h0000);
		chk("bypass left", 16'h0003, 16'(rmode));
		$display("bypass test ended");
	endtask

	task erase_open;
		unlock(8'h01, 4'h0);
		w(8'h01, 4'h0, 16'h0AAA, 16'h0080);
		unlock(8'h01, 4'h0);
	endtask

	task t_erase;
		w(8'h01, 4'h0, 16'h0000, 16'h00B0);
		chk("idle suspend", 16'h0000, 16'(susp));
		seen = 2'b00;
		erase_open();
		w(8'h01, 4'h0, 16'h0AAA, 16'h0010);
		wait_start(20);
		chk("bulk kind", 16'h0003, 16'(kind_s[1:0]));
		eng(2'b01, 1'b0);
		seen = 2'b00;
		erase_open();
		w(8'h10, 4'h0, 16'h4000, 16'h0030);
		w(8'h20, 4'h0, 16'h5000, 16'h0030);
		wait_start(25000);
		chk("sector kind", 16'h0002, 16'(kind_s[1:0]));
		w(8'h10, 4'h0, 16'h0000, 16'h00B0);
		chk("suspended", 16'h0001, 16'(susp));
		w(8'h10, 4'h0, 16'h0000, 16'h0030);
		chk("resumed", 16'h0000, 16'(susp));
		eng(2'b01, 1'b1);
		chk("error set", 16'h0001, 16'(err));
		w(8'h01, 4'h0, 16'h0000, 16'h00F0);
		chk("error cleared", 16'h0000, 16'(err));
		$display("erase test ended");
	endtask

	// reset, then each scenario in turn
	initial
	begin
		rst_n = 1'b0;
		done = 2'b00;
		fail = 2'b00;
		pprot = 8'h00;
		sprot = 4'h0;
		seen = 2'b00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("reset mode", 16'h0003, 16'(rmode));
		t_program();
		t_autosel();
		t_bad();
		t_bypass();
		t_erase();
		tally_and_finish();
	end
endmodule
